// *** src/rtc_map.vh ***
`ifndef RTC_MAP_VH
`define RTC_MAP_VH

// ----------------------------------------------------------------------
// register indices (byte address on apb is four times the index)
// ----------------------------------------------------------------------
`define RTC_IDX_MAIN_CONTROL    6'h00
`define RTC_IDX_SYNC_BUSY       6'h01
`define RTC_IDX_IRQ_ENABLE      6'h02
`define RTC_IDX_IRQ_FLAGS       6'h03
`define RTC_IDX_BYTE_STAGING    6'h04
`define RTC_IDX_HALT_BEHAVIOUR  6'h05
`define RTC_IDX_CRYSTAL_TRIM    6'h06
`define RTC_IDX_SOURCE_SELECT   6'h07
`define RTC_IDX_COUNT_LO        6'h08
`define RTC_IDX_COUNT_HI        6'h09
`define RTC_IDX_LIMIT_LO        6'h0A
`define RTC_IDX_LIMIT_HI        6'h0B
`define RTC_IDX_COMPARE_LO      6'h0C
`define RTC_IDX_COMPARE_HI      6'h0D

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define RTC_CTL_COUNTER_ON      0
`define RTC_CTL_CORRECTION_ON   2
`define RTC_CTL_PRESC_LSB       3
`define RTC_CTL_PRESC_MSB       6
`define RTC_BUSY_CONTROL        0
`define RTC_BUSY_COUNT          1
`define RTC_BUSY_LIMIT          2
`define RTC_BUSY_COMPARE        3
`define RTC_IRQ_WRAP            0
`define RTC_IRQ_MATCH           1
`define RTC_HALT_RUN            0
`define RTC_TRIM_SIGN           7
`define RTC_TRIM_MAG_MSB        6
`define RTC_SRC_MSB             1

// ----------------------------------------------------------------------
// source select codes
// ----------------------------------------------------------------------
`define RTC_SRC_INTERNAL_SLOW_OSC     2'h0
`define RTC_SRC_INTERNAL_KHZ_TAP      2'h1
`define RTC_SRC_EXTERNAL_SLOW_CRYSTAL 2'h2
`define RTC_SRC_EXTERNAL_CLOCK_INPUT  2'h3

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RTC_RST_BYTE            8'h00
`define RTC_RST_COUNT           16'h0000
`define RTC_RST_LIMIT           16'hFFFF
`define RTC_RST_COMPARE         16'h0000

// ----------------------------------------------------------------------
// timing counts, in counter clock ticks
// ----------------------------------------------------------------------
`define RTC_SYNC_TICKS          2'h2
`define RTC_PPM_LAST            20'hF423F

`endif

// *** src/rtc_sync_stage.v ***
`include "rtc_map.vh"
`default_nettype none

// carries one value written on the bus into the counter domain; the value
// takes effect on the second selected counter tick after the write
module rtc_sync_stage #(
  parameter       W   = 16,
  parameter [W-1:0] RST = {W{1'b0}}
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire         wr,
  input  wire [W-1:0] wdata,
  input  wire         tick,
  output reg          busy_ff,
  output reg          load_ff,
  output reg  [W-1:0] val_ff
);

  reg [W-1:0] pend_ff;
  reg [1:0]   cnt_ff;

  // ----------------------------------------------------------------------
  // pending value and tick counting
  // ----------------------------------------------------------------------
  // a rewrite while busy restarts the count; software should not do it
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pend_ff <= RST;
      val_ff  <= RST;
      busy_ff <= 1'b0;
      load_ff <= 1'b0;
      cnt_ff  <= 2'h0;
    end
    else
    begin
      load_ff <= 1'b0;
      if (wr)
      begin
        pend_ff <= wdata;
        busy_ff <= 1'b1;
        cnt_ff  <= 2'h0;
      end
      else if (busy_ff && tick)
      begin
        if (cnt_ff == `RTC_SYNC_TICKS - 2'h1)
        begin
          val_ff  <= pend_ff;
          busy_ff <= 1'b0;
          load_ff <= 1'b1;
        end
        else
        begin
          cnt_ff <= cnt_ff + 2'h1;
        end
      end
    end
  end

endmodule

`default_nettype wire

// *** src/rtc_prescale.v ***
`include "rtc_map.vh"
`default_nettype none

// divides counter ticks by two to the power div_sel, with ppm trim that
// skips or doubles prescaler increments at the start of each interval after the first
module rtc_prescale (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       tick,
  input  wire [3:0] div_sel,
  input  wire       trim_on,
  input  wire       trim_sign,
  input  wire [6:0] trim_mag,
  output reg        step_ff
);

  reg  [15:0] pre_ff;
  reg  [19:0] ppm_ff;
  reg  [6:0]  left_ff;
  wire [15:0] mask;
  wire        adjust;
  wire [16:0] inc;
  wire [16:0] sum;

  assign mask   = (16'h0001 << div_sel) - 16'h0001;
  assign adjust = trim_on && (left_ff != 7'h00);
  // sign zero holds the prescaler back, sign one advances it twice
  assign inc    = adjust ? (trim_sign ? 17'h00002 : 17'h00000)
                         : 17'h00001;
  assign sum    = {1'b0, pre_ff & mask} + inc;

  // ----------------------------------------------------------------------
  // prescaler and correction interval
  // ----------------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pre_ff  <= 16'h0000;
      ppm_ff  <= 20'h00000;
      left_ff <= 7'h00;
      step_ff <= 1'b0;
    end
    else
    begin
      step_ff <= tick && (sum > {1'b0, mask});
      if (tick)
      begin
        pre_ff <= sum[15:0] & mask;
        if (ppm_ff == `RTC_PPM_LAST)
        begin
          ppm_ff  <= 20'h00000;
          left_ff <= trim_mag;
        end
        else
        begin
          ppm_ff <= ppm_ff + 20'h00001;
          if (adjust)
            left_ff <= left_ff - 7'h01;
        end
      end
    end
  end

endmodule

`default_nettype wire

// *** src/rtc_counter_bank.v ***
// The APB register port is this design's own decision.
`include "rtc_map.vh"
`default_nettype none

module rtc_counter_bank (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata_ff,
  output reg         pready_ff,
  output reg         pslverr_ff,
  input  wire        internal_slow_osc,
  input  wire        internal_khz_tap,
  input  wire        external_slow_crystal,
  input  wire        external_clock_input,
  input  wire        cpu_halted,
  output reg         irq_ff
);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  reg  [7:0]  ctl_reg_ff;
  reg  [1:0]  irq_enable_ff;
  reg  [1:0]  irq_flags_ff;
  reg  [7:0]  byte_staging_ff;
  reg         run_when_halted_ff;
  reg  [7:0]  crystal_trim_ff;
  reg  [1:0]  source_select_ff;
  reg  [15:0] count_value_ff;
  reg  [15:0] limit_reg_ff;
  reg  [15:0] compare_reg_ff;
  reg         wrap_evt_ff;
  reg         match_evt_ff;
  reg  [1:0]  evt_stage_ff;
  reg  [31:0] nxt_prdata;
  reg         nxt_slverr;
  reg  [7:0]  nxt_staging;
  reg  [15:0] nxt_count;

  wire [5:0]  idx;
  wire        addr_ok;
  wire        setup_rd;
  wire        done;
  wire        wr_en;
  wire        rd_lo_count;
  wire        rd_lo_limit;
  wire        rd_lo_compare;
  wire [15:0] wide_wdata;
  wire        wr_ctl;
  wire        wr_count;
  wire        wr_limit;
  wire        wr_compare;
  reg         tick_src;
  wire        run;
  wire        step;
  wire [7:0]  ctl_eff;
  wire [15:0] count_load;
  wire [15:0] limit_eff;
  wire [15:0] compare_eff;
  wire        count_load_p;
  wire        busy_ctl;
  wire        busy_count;
  wire        busy_limit;
  wire        busy_compare;
  wire [7:0]  busy_byte;

  // ----------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------
  // one wait state: pready rises in the second access cycle, so the
  // read mux and its staging side effect are taken one edge early
  assign idx      = paddr[7:2];
  assign addr_ok  = (paddr[1:0] == 2'h0) &&
                    (idx <= `RTC_IDX_COMPARE_HI);
  assign setup_rd = psel && penable && !pready_ff && !pwrite;
  assign done     = psel && penable && pready_ff;
  assign wr_en    = done && pwrite && addr_ok;

  // low-byte reads park the high byte in the staging register
  assign rd_lo_count   = setup_rd && (idx == `RTC_IDX_COUNT_LO);
  assign rd_lo_limit   = setup_rd && (idx == `RTC_IDX_LIMIT_LO);
  assign rd_lo_compare = setup_rd && (idx == `RTC_IDX_COMPARE_LO);

  // a high-byte write pairs with the byte parked by the low-byte write
  assign wide_wdata = {pwdata[7:0], byte_staging_ff};
  assign wr_ctl     = wr_en && (idx == `RTC_IDX_MAIN_CONTROL);
  assign wr_count   = wr_en && (idx == `RTC_IDX_COUNT_HI);
  assign wr_limit   = wr_en && (idx == `RTC_IDX_LIMIT_HI);
  assign wr_compare = wr_en && (idx == `RTC_IDX_COMPARE_HI);

  assign busy_byte = {4'h0, busy_compare, busy_limit, busy_count,
                      busy_ctl};

  // ----------------------------------------------------------------------
  // apb handshake
  // ----------------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h00000000;
    end
    else
    begin
      pready_ff  <= psel && penable && !pready_ff;
      pslverr_ff <= psel && penable && !pready_ff && nxt_slverr;
      if (setup_rd)
        prdata_ff <= nxt_prdata;
    end
  end

  // read mux; indices past the map read zero; those and misaligned addresses answer with an error
  always @*
  begin
    nxt_prdata = 32'h00000000;
    nxt_slverr = !addr_ok;
    case (idx)
      `RTC_IDX_MAIN_CONTROL:   nxt_prdata[7:0] = ctl_reg_ff;
      `RTC_IDX_SYNC_BUSY:      nxt_prdata[7:0] = busy_byte;
      `RTC_IDX_IRQ_ENABLE:     nxt_prdata[1:0] = irq_enable_ff;
      `RTC_IDX_IRQ_FLAGS:      nxt_prdata[1:0] = irq_flags_ff;
      `RTC_IDX_BYTE_STAGING:   nxt_prdata[7:0] = byte_staging_ff;
      `RTC_IDX_HALT_BEHAVIOUR: nxt_prdata[0]   = run_when_halted_ff;
      `RTC_IDX_CRYSTAL_TRIM:   nxt_prdata[7:0] = crystal_trim_ff;
      `RTC_IDX_SOURCE_SELECT:  nxt_prdata[1:0] = source_select_ff;
      `RTC_IDX_COUNT_LO:       nxt_prdata[7:0] = count_value_ff[7:0];
      `RTC_IDX_LIMIT_LO:       nxt_prdata[7:0] = limit_reg_ff[7:0];
      `RTC_IDX_COMPARE_LO:     nxt_prdata[7:0] = compare_reg_ff[7:0];
      `RTC_IDX_COUNT_HI,
      `RTC_IDX_LIMIT_HI,
      `RTC_IDX_COMPARE_HI:     nxt_prdata[7:0] = byte_staging_ff;
      default:                 nxt_prdata = 32'h00000000;
    endcase
  end

  // ----------------------------------------------------------------------
  // byte staging register
  // ----------------------------------------------------------------------
  // low-byte writes and direct writes load it; low-byte reads load it
  // with the high byte so a later high read sees a coherent pair
  always @*
  begin
    nxt_staging = byte_staging_ff;
    if (rd_lo_count)
      nxt_staging = count_value_ff[15:8];
    else if (rd_lo_limit)
      nxt_staging = limit_reg_ff[15:8];
    else if (rd_lo_compare)
      nxt_staging = compare_reg_ff[15:8];
    else if (wr_en && ((idx == `RTC_IDX_BYTE_STAGING) ||
                       (idx == `RTC_IDX_COUNT_LO) ||
                       (idx == `RTC_IDX_LIMIT_LO) ||
                       (idx == `RTC_IDX_COMPARE_LO)))
      nxt_staging = pwdata[7:0];
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      byte_staging_ff <= `RTC_RST_BYTE;
    else
      byte_staging_ff <= nxt_staging;
  end

  // ----------------------------------------------------------------------
  // plain control registers
  // ----------------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctl_reg_ff         <= `RTC_RST_BYTE;
      irq_enable_ff      <= 2'h0;
      run_when_halted_ff <= 1'b0;
      crystal_trim_ff    <= `RTC_RST_BYTE;
      source_select_ff   <= 2'h0;
      limit_reg_ff       <= `RTC_RST_LIMIT;
      compare_reg_ff     <= `RTC_RST_COMPARE;
    end
    else
    begin
      if (wr_ctl)
        ctl_reg_ff <= pwdata[7:0];
      if (wr_en && (idx == `RTC_IDX_IRQ_ENABLE))
        irq_enable_ff <= pwdata[1:0];
      if (wr_en && (idx == `RTC_IDX_HALT_BEHAVIOUR))
        run_when_halted_ff <= pwdata[`RTC_HALT_RUN];
      if (wr_en && (idx == `RTC_IDX_CRYSTAL_TRIM))
        crystal_trim_ff <= pwdata[7:0];
      if (wr_en && (idx == `RTC_IDX_SOURCE_SELECT))
        source_select_ff <= pwdata[`RTC_SRC_MSB:0];
      if (wr_limit)
        limit_reg_ff <= wide_wdata;
      if (wr_compare)
        compare_reg_ff <= wide_wdata;
    end
  end

  // ----------------------------------------------------------------------
  // counter clock source
  // ----------------------------------------------------------------------
  // ticks arrive as one-cycle enables already aligned to pclk
  always @*
  begin
    case (source_select_ff)
      `RTC_SRC_INTERNAL_SLOW_OSC:     tick_src = internal_slow_osc;
      `RTC_SRC_INTERNAL_KHZ_TAP:      tick_src = internal_khz_tap;
      `RTC_SRC_EXTERNAL_SLOW_CRYSTAL: tick_src = external_slow_crystal;
      `RTC_SRC_EXTERNAL_CLOCK_INPUT:  tick_src = external_clock_input;
      default:                        tick_src = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // carrying writes into the counter domain
  // ----------------------------------------------------------------------
  rtc_sync_stage #(
    .W   (8),
    .RST (`RTC_RST_BYTE)
  ) u_sync_ctl (
    .pclk    (pclk),
    .presetn (presetn),
    .wr      (wr_ctl),
    .wdata   (pwdata[7:0]),
    .tick    (tick_src),
    .busy_ff (busy_ctl),
    .load_ff (),
    .val_ff  (ctl_eff)
  );

  rtc_sync_stage #(
    .W   (16),
    .RST (`RTC_RST_COUNT)
  ) u_sync_count (
    .pclk    (pclk),
    .presetn (presetn),
    .wr      (wr_count),
    .wdata   (wide_wdata),
    .tick    (tick_src),
    .busy_ff (busy_count),
    .load_ff (count_load_p),
    .val_ff  (count_load)
  );

  rtc_sync_stage #(
    .W   (16),
    .RST (`RTC_RST_LIMIT)
  ) u_sync_limit (
    .pclk    (pclk),
    .presetn (presetn),
    .wr      (wr_limit),
    .wdata   (wide_wdata),
    .tick    (tick_src),
    .busy_ff (busy_limit),
    .load_ff (),
    .val_ff  (limit_eff)
  );

  rtc_sync_stage #(
    .W   (16),
    .RST (`RTC_RST_COMPARE)
  ) u_sync_compare (
    .pclk    (pclk),
    .presetn (presetn),
    .wr      (wr_compare),
    .wdata   (wide_wdata),
    .tick    (tick_src),
    .busy_ff (busy_compare),
    .load_ff (),
    .val_ff  (compare_eff)
  );

  // ----------------------------------------------------------------------
  // prescaler and counter
  // ----------------------------------------------------------------------
  // debug halt, unless run_when_halted_ff is set, drops ticks, which freezes prescaler, trim and counter
  assign run = ctl_eff[`RTC_CTL_COUNTER_ON] &&
               (run_when_halted_ff || !cpu_halted);

  rtc_prescale u_prescale (
    .pclk      (pclk),
    .presetn   (presetn),
    .tick      (tick_src && run),
    .div_sel   (ctl_eff[`RTC_CTL_PRESC_MSB:`RTC_CTL_PRESC_LSB]),
    .trim_on   (ctl_eff[`RTC_CTL_CORRECTION_ON]),
    .trim_sign (crystal_trim_ff[`RTC_TRIM_SIGN]),
    .trim_mag  (crystal_trim_ff[`RTC_TRIM_MAG_MSB:0]),
    .step_ff   (step)
  );

  always @*
  begin
    if (count_value_ff == limit_eff)
      nxt_count = 16'h0000;
    else
      nxt_count = count_value_ff + 16'h0001;
  end

  // a count load wins over a step in the same cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_value_ff <= `RTC_RST_COUNT;
      wrap_evt_ff    <= 1'b0;
      match_evt_ff   <= 1'b0;
    end
    else
    begin
      wrap_evt_ff  <= 1'b0;
      match_evt_ff <= 1'b0;
      if (count_load_p)
        count_value_ff <= count_load;
      else if (step && run)
      begin
        count_value_ff <= nxt_count;
        wrap_evt_ff    <= (count_value_ff == limit_eff);
        match_evt_ff   <= (nxt_count == compare_eff);
      end
    end
  end

  // ----------------------------------------------------------------------
  // event flags and interrupt request
  // ----------------------------------------------------------------------
  // events pass one more stage, then set flags; a set wins over a clear
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      evt_stage_ff <= 2'h0;
      irq_flags_ff <= 2'h0;
      irq_ff       <= 1'b0;
    end
    else
    begin
      evt_stage_ff <= {match_evt_ff, wrap_evt_ff};
      if (wr_en && (idx == `RTC_IDX_IRQ_FLAGS))
        irq_flags_ff <= (irq_flags_ff & ~pwdata[1:0]) |
                        evt_stage_ff;
      else
        irq_flags_ff <= irq_flags_ff | evt_stage_ff;
      irq_ff <= |(irq_flags_ff & irq_enable_ff);
    end
  end

endmodule

`default_nettype wire

// *** testbench/rtc_bank_checker.sv ***
`default_nettype none
// --------------------------------
// port checker for the register bank
// --------------------------------
module rtc_bank_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata_ff,
  input wire logic        pready_ff,
  input wire logic        pslverr_ff,
  input wire logic        internal_slow_osc,
  input wire logic        internal_khz_tap,
  input wire logic        external_slow_crystal,
  input wire logic        external_clock_input,
  input wire logic        cpu_halted,
  input wire logic        irq_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr_irq;
  // enable or flag writes may drop the interrupt two cycles later
  assign wr_irq = pready_ff & pwrite & (paddr == 8'h08 | paddr == 8'h0C);

  a_ready_wait: assert property (psel & penable & !$past(penable)
    |-> !pready_ff ##1 pready_ff) else $error("ready not after one wait");
  a_ready_once: assert property (pready_ff |=> !pready_ff)
    else $error("ready held too long");
  a_err_map: assert property (pready_ff |-> pslverr_ff ==
    (paddr[7:2] > 6'h0D || paddr[1:0] != 2'h0)) else $error("bad error");
  a_err_ready: assert property (pslverr_ff |-> pready_ff && psel)
    else $error("error without ready");
  a_rd_upper: assert property (pready_ff && !pwrite |->
    prdata_ff[31:8] == 24'h0) else $error("upper read bits set");
  a_busy_bits: assert property (pready_ff && !pwrite && paddr == 8'h04
    |-> prdata_ff[7:4] == 4'h0) else $error("busy spare bits set");
  a_irq_hold: assert property (irq_ff && !wr_irq && !$past(wr_irq)
    |=> irq_ff) else $error("interrupt dropped by itself");
  a_rd_stand: assert property (!$past(psel) || $past(pwrite)
    |-> $stable(prdata_ff)) else $error("read data moved");
  c_irq: cover property ($rose(irq_ff));
  c_err: cover property (pslverr_ff);
  c_busy: cover property (pready_ff && paddr == 8'h04 && prdata_ff != 0);
endmodule

bind rtc_counter_bank rtc_bank_checker i_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff),
  .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
  .internal_slow_osc(internal_slow_osc),
  .internal_khz_tap(internal_khz_tap),
  .external_slow_crystal(external_slow_crystal),
  .external_clock_input(external_clock_input),
  .cpu_halted(cpu_halted), .irq_ff(irq_ff));
`default_nettype wire

// *** testbench/testbench.sv ***
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, cpu_halted, ton, rerr;
  logic [7:0]  paddr, rv;
  logic [31:0] pwdata;
  wire  [31:0] prdata_ff;
  wire         pready_ff, pslverr_ff, irq_ff;
  logic [3:0]  tick = 4'h0, tdiv = 4'h0;
  logic [1:0]  tsrc, c0;
  int          fail_count, compares, n, s, nt;

  rtc_counter_bank i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
    .internal_slow_osc(tick[0]), .internal_khz_tap(tick[1]),
    .external_slow_crystal(tick[2]), .external_clock_input(tick[3]),
    .cpu_halted(cpu_halted), .irq_ff(irq_ff));

  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // --------------------------------
  // counter ticks, one every 16 cycles
  // --------------------------------
  always @(posedge pclk)
  begin
    tdiv <= tdiv + 4'h1;
    tick <= (ton && tdiv == 4'hF) ? 4'h1 << tsrc : 4'h0;
    // ticks seen so far, so a test can run an exact number of them
    if (|tick)
      nt <= nt + 1;
  end

  task automatic chk(input string nm, input logic [15:0] e, g);
    compares++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  // one apb transfer; idle cycle after so psel never toggles twice a step
  task automatic xfer(input logic w, input logic [5:0] i, [7:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    // no own limit here: only the watchdog ends a hung wait
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready_ff !== 1'b1);
    rv = prdata_ff[7:0];
    rerr = pslverr_ff;
    chk("wait states", 16'h2, k[15:0]);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    xfer(1'b1, i, d);
  endtask

  task automatic rd(input string nm, input logic [5:0] i, [7:0] e);
    xfer(1'b0, i, 8'h00);
    chk(nm, {8'h0, e}, {8'h0, rv});
  endtask

  // low byte read parks the high byte in staging
  task automatic rd16(input string nm, input logic [5:0] i, [15:0] e);
    logic [7:0] lo;
    xfer(1'b0, i, 8'h00);
    lo = rv;
    xfer(1'b0, i + 6'h1, 8'h00);
    chk(nm, e, {rv, lo});
  endtask

  task automatic idle_busy;
    for (n = 0; n < 100; n++)
    begin
      xfer(1'b0, 6'h01, 8'h00);
      if (rv === 8'h00) break;
    end
    chk("busy", 16'h0, {8'h0, rv});
  endtask

  task automatic wait_irq;
    for (n = 0; n < 400 && irq_ff !== 1'b1; n++) @(posedge pclk);
    chk("irq", 16'h1, {15'h0, irq_ff});
  endtask

  task automatic summarize;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    #(40000 * 4);
    $display("timeout");
    fail_count++;
    summarize();
  end

  initial
  begin
    {psel, penable, pwrite, cpu_halted, ton, presetn} = 6'h0;
    {paddr, pwdata, tsrc} = 0;
    fail_count = 0;
    compares = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (s = 1; s < 8; s++) rd("reset", s[5:0], 8'h00);
    rd16("count", 6'h08, 16'h0000);
    rd16("limit", 6'h0A, 16'hFFFF);
    wr(6'h04, 8'hA5);
    rd("staging", 6'h04, 8'hA5);
    rd("unmapped", 6'h0E, 8'h00);
    chk("slave error", 16'h1, {15'h0, rerr});
    $display("test registers done");
    rd("busy", 6'h01, 8'h00);
    wr(6'h0A, 8'h03);
    rd("staging", 6'h04, 8'h03);
    wr(6'h0B, 8'h00);
    rd("busy", 6'h01, 8'h04);
    rd16("limit", 6'h0A, 16'h0003);
    wr(6'h0C, 8'h02);
    wr(6'h0D, 8'h00);
    rd("busy", 6'h01, 8'h0C);
    rd16("compare", 6'h0C, 16'h0002);
    wr(6'h00, 8'h01);
    rd("busy", 6'h01, 8'h0D);
    wr(6'h08, 8'h01);
    wr(6'h09, 8'h00);
    rd("busy", 6'h01, 8'h0F);
    ton <= 1'b1;
    idle_busy();
    wr(6'h02, 8'h02);
    wait_irq();
    ton <= 1'b0;
    rd("flags", 6'h03, 8'h02);
    wr(6'h03, 8'h01);
    rd("flags", 6'h03, 8'h02);
    wr(6'h03, 8'h02);
    rd("flags", 6'h03, 8'h00);
    chk("irq", 16'h0, {15'h0, irq_ff});
    wr(6'h02, 8'h00);
    ton <= 1'b1;
    for (n = 0; n < 60 && rv[0] !== 1'b1; n++) xfer(1'b0, 6'h03, 8'h00);
    ton <= 1'b0;
    chk("flags", 16'h1, {8'h0, rv});
    chk("irq", 16'h0, {15'h0, irq_ff});
    rd16("count", 6'h08, 16'h0000);
    wr(6'h03, 8'h03);
    $display("test events done");
    cpu_halted <= 1'b1;
    wr(6'h02, 8'h01);
    ton <= 1'b1;
    repeat (200) @(posedge pclk);
    rd("flags", 6'h03, 8'h00);
    wr(6'h05, 8'h01);
    wait_irq();
    cpu_halted <= 1'b0;
    ton <= 1'b0;
    wr(6'h03, 8'h03);
    $display("test halt done");
    for (s = 0; s < 4; s++)
    begin
      tsrc <= s[1:0];
      wr(6'h07, s[7:0]);
      rd("source", 6'h07, s[7:0]);
      idle_busy();
      wr(6'h08, 8'h00);
      wr(6'h09, 8'h00);
      ton <= 1'b1;
      idle_busy();
      ton <= 1'b0;
    end
    $display("test sources done");
    // divide by two before a negative trim; four ticks give two steps
    wr(6'h00, 8'h0D);
    ton <= 1'b1;
    idle_busy();
    wr(6'h06, 8'h85);
    rd("trim", 6'h06, 8'h85);
    ton <= 1'b0;
    repeat (4) @(posedge pclk);
    xfer(1'b0, 6'h08, 8'h00);
    c0 = rv[1:0];
    n = nt;
    ton <= 1'b1;
    while (nt != n + 4) @(posedge pclk);
    ton <= 1'b0;
    rd("prescale", 6'h08, {6'h0, c0 + 2'h2});
    $display("test prescale done");
    summarize();
  end
endmodule
`default_nettype wire
